// ===== rtl/trigger_encoder_select.sv
// trigger and encoder source select, conditioning, frame end flag and camera control sync
`timescale 1ns/1ps
module trigger_encoder_select #(
    parameter int SYNC_STAGES = trig_enc_pkg::SYNC_STAGES,
    parameter int CC_WIDTH = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire trig_enc_pkg::io_pins_t trigger_pins,
    input wire trig_enc_pkg::io_pins_t encoder_pins,
    input wire logic frame_valid,
    input wire logic primary_pixel_clock,
    input wire logic secondary_pixel_clock,
    input wire logic line_pulse,
    input wire logic vertical_active_window,
    input wire logic [CC_WIDTH-1:0] cc_primary_request,
    input wire logic [CC_WIDTH-1:0] cc_secondary_request,
    output logic trigger_active,
    output logic trigger_pulse,
    output logic encoder_active,
    output logic encoder_pulse,
    output logic frame_end_irq,
    output logic [CC_WIDTH-1:0] camera_control_output_primary,
    output logic [CC_WIDTH-1:0] camera_control_output_secondary
);
    localparam int NPIN = 9;
    localparam int CNT_W = trig_enc_pkg::DELAY_W + trig_enc_pkg::LINE_STEP_SHIFT;

    if (SYNC_STAGES < 2) begin
        $error("SYNC_STAGES must be at least 2");
    end
    if (CC_WIDTH < 1 || CC_WIDTH > 32) begin
        $error("CC_WIDTH must be 1 to 32");
    end

    logic [SYNC_STAGES-1:0][NPIN-1:0] sync_q;
    logic [NPIN-1:0] pins_async;
    logic [NPIN-1:0] pins_s;

    assign pins_async = {secondary_pixel_clock, primary_pixel_clock, frame_valid, encoder_pins, trigger_pins};

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], pins_async};
        end
    end

    assign pins_s = sync_q[SYNC_STAGES-1];

    trig_enc_pkg::io_pins_t trig_s;
    trig_enc_pkg::io_pins_t enc_s;
    logic fv_s;
    logic pclk1_s;
    logic pclk2_s;

    assign trig_s = pins_s[2:0];
    assign enc_s = pins_s[5:3];
    assign fv_s = pins_s[6];
    assign pclk1_s = pins_s[7];
    assign pclk2_s = pins_s[8];

    // register state
    logic [31:0] tec_q;
    logic irq_mask_q;
    logic eof_flag_q;
    logic [5:0] cfg_q;
    logic ack_q;
    logic [31:0] dat_r_q;

    trig_enc_pkg::src_sel_t trig_sel;
    trig_enc_pkg::src_sel_t enc_sel;
    trig_enc_pkg::camera_control_sync_select_t cc_sel;
    logic [3:0] cmd_code;

    assign trig_sel = trig_enc_pkg::src_sel_t'(tec_q[trig_enc_pkg::TRIG_SEL_LSB +: 2]);
    assign enc_sel = trig_enc_pkg::src_sel_t'(tec_q[trig_enc_pkg::ENC_SEL_LSB +: 2]);
    assign cc_sel = trig_enc_pkg::camera_control_sync_select_t'(tec_q[trig_enc_pkg::CAMERA_CONTROL_SYNC_SELECT_LSB +: 3]);
    assign cmd_code = cfg_q[trig_enc_pkg::CMD_LSB +: 4];

    // bus decode
    logic req;
    logic wr;
    logic hit_tec;
    logic hit_acq;
    logic hit_cfg;

    assign req = wb_cyc & wb_stb & ~ack_q;
    assign wr = req & wb_we;
    assign hit_tec = (wb_adr == trig_enc_pkg::TEC_OFFSET);
    assign hit_acq = (wb_adr == trig_enc_pkg::ACQ_OFFSET);
    assign hit_cfg = (wb_adr == trig_enc_pkg::CFG_OFFSET);

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tec_q <= trig_enc_pkg::TEC_RESET;
        end else if (wr && hit_tec) begin
            tec_q <= lane_merge(tec_q, wb_dat_w, wb_sel) & trig_enc_pkg::TEC_RW_MASK;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_mask_q <= 1'b0;
        end else if (wr && hit_acq && wb_sel[3]) begin
            irq_mask_q <= wb_dat_w[trig_enc_pkg::IRQ_MASK_BIT];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_q <= trig_enc_pkg::CFG_RESET;
        end else if (wr && hit_cfg && wb_sel[0]) begin
            cfg_q <= wb_dat_w[5:0];
        end
    end

    // live readback composition
    logic [31:0] tec_read;
    logic [31:0] acq_read;

    always_comb begin
        tec_read = tec_q & trig_enc_pkg::TEC_RW_MASK;
        tec_read[trig_enc_pkg::TRIG_LEVEL_LSB +: 3] = trig_s;
        tec_read[trig_enc_pkg::ENC_LEVEL_LSB +: 3] = enc_s;
        tec_read[trig_enc_pkg::FV_LEVEL_BIT] = fv_s;
        acq_read = 32'h0000_0000;
        acq_read[trig_enc_pkg::IRQ_MASK_BIT] = irq_mask_q;
        acq_read[trig_enc_pkg::EOF_FLAG_BIT] = eof_flag_q;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
            dat_r_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !wb_we) begin
                if (hit_tec) begin
                    dat_r_q <= tec_read;
                end else if (hit_acq) begin
                    dat_r_q <= acq_read;
                end else if (hit_cfg) begin
                    dat_r_q <= {26'h0, cfg_q};
                end else begin
                    dat_r_q <= 32'h0000_0000;
                end
            end
        end
    end

    // trigger conditioning
    logic trig_raw;
    logic trig_pol;
    logic trig_comb;
    logic trig_lvl_q;
    logic trig_event;
    logic trig_fall;

    always_comb begin
        trig_raw = 1'b0;
        unique case (trig_sel)
            trig_enc_pkg::SRC_DIFF: trig_raw = trig_s.diff;
            trig_enc_pkg::SRC_TTL: trig_raw = trig_s.ttl;
            trig_enc_pkg::SRC_OPTO: trig_raw = trig_s.opto;
            trig_enc_pkg::SRC_CAMERA: trig_raw = fv_s;
        endcase
        trig_pol = (trig_sel == trig_enc_pkg::SRC_CAMERA) ? cfg_q[trig_enc_pkg::FV_POL_BIT]
                                                          : tec_q[trig_enc_pkg::TRIG_POL_BIT];
        trig_comb = (tec_q[trig_enc_pkg::TRIG_EN_BIT] & (trig_raw ^ trig_pol))
                    | tec_q[trig_enc_pkg::SOFT_TRIG_BIT];
    end

    assign trig_event = trig_comb & ~trig_lvl_q;
    assign trig_fall = ~trig_comb & trig_lvl_q;

    // encoder conditioning
    logic enc_raw;
    logic enc_comb;
    logic enc_lvl_q;
    logic enc_pulse_q;

    always_comb begin
        enc_raw = 1'b0;
        // encoder source select, reserved code passes nothing
        unique case (enc_sel)
            trig_enc_pkg::SRC_DIFF: enc_raw = enc_s.diff;
            trig_enc_pkg::SRC_TTL: enc_raw = enc_s.ttl;
            trig_enc_pkg::SRC_OPTO: enc_raw = enc_s.opto;
            trig_enc_pkg::SRC_CAMERA: enc_raw = 1'b0;
        endcase
        enc_comb = (tec_q[trig_enc_pkg::ENC_EN_BIT] & (enc_raw ^ tec_q[trig_enc_pkg::ENC_POL_BIT]))
                   | tec_q[trig_enc_pkg::SOFT_ENC_BIT];
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            trig_lvl_q <= 1'b0;
            enc_lvl_q <= 1'b0;
            enc_pulse_q <= 1'b0;
        end else begin
            trig_lvl_q <= trig_comb;
            enc_lvl_q <= enc_comb;
            enc_pulse_q <= enc_comb & ~enc_lvl_q;
        end
    end

    // trigger line delay
    logic [CNT_W-1:0] delay_cnt_q;
    logic delay_busy_q;
    logic trig_pulse_q;
    logic [trig_enc_pkg::DELAY_W-1:0] delay_n;

    assign delay_n = tec_q[trig_enc_pkg::DELAY_LSB +: trig_enc_pkg::DELAY_W];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            delay_cnt_q <= '0;
            delay_busy_q <= 1'b0;
            trig_pulse_q <= 1'b0;
        end else begin
            trig_pulse_q <= 1'b0;
            if (!delay_busy_q) begin
                if (trig_event) begin
                    if (delay_n == '0) begin
                        trig_pulse_q <= 1'b1;
                    end else begin
                        delay_busy_q <= 1'b1;
                        delay_cnt_q <= {delay_n, 3'b000};
                    end
                end
            end else if (line_pulse) begin
                delay_cnt_q <= delay_cnt_q - 1'b1;
                if (delay_cnt_q == CNT_W'(1)) begin
                    delay_busy_q <= 1'b0;
                    trig_pulse_q <= 1'b1;
                end
            end
        end
    end

    // frame end flag
    logic vaw_q;
    logic vaw_end;
    logic host_flag_wr;
    logic eof_set;
    logic eof_clr;
    logic irq_q;

    // flag writes only under the command code
    assign host_flag_wr = wr & hit_acq & wb_sel[3] & (cmd_code == trig_enc_pkg::CMD_FLAG_WRITE);
    assign vaw_end = vaw_q & ~vertical_active_window;
    assign eof_set = vaw_end | (cfg_q[trig_enc_pkg::START_STOP_BIT] & trig_fall)
                     | (host_flag_wr & wb_dat_w[trig_enc_pkg::EOF_FLAG_BIT]);
    assign eof_clr = host_flag_wr & ~wb_dat_w[trig_enc_pkg::EOF_FLAG_BIT];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            vaw_q <= 1'b0;
            eof_flag_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            vaw_q <= vertical_active_window;
            if (eof_set) begin
                eof_flag_q <= 1'b1;
            end else if (eof_clr) begin
                eof_flag_q <= 1'b0;
            end
            irq_q <= eof_flag_q & irq_mask_q;
        end
    end

    // camera control output sync
    logic pclk1_q;
    logic pclk2_q;
    logic pclk1_edge;
    logic pclk2_edge;
    logic cc1_load;
    logic cc2_load;
    logic [CC_WIDTH-1:0] cc1_q;
    logic [CC_WIDTH-1:0] cc2_q;

    assign pclk1_edge = pclk1_s & ~pclk1_q;
    assign pclk2_edge = pclk2_s & ~pclk2_q;

    always_comb begin
        // pick the update edge per connector
        case (cc_sel)
            trig_enc_pkg::CC_PRIMARY: begin
                cc1_load = pclk1_edge;
                cc2_load = pclk1_edge;
            end
            trig_enc_pkg::CC_SECONDARY: begin
                cc1_load = pclk2_edge;
                cc2_load = pclk2_edge;
            end
            trig_enc_pkg::CC_OWN: begin
                cc1_load = pclk1_edge;
                cc2_load = pclk2_edge;
            end
            default: begin
                cc1_load = 1'b1;
                cc2_load = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pclk1_q <= 1'b0;
            pclk2_q <= 1'b0;
            cc1_q <= '0;
            cc2_q <= '0;
        end else begin
            pclk1_q <= pclk1_s;
            pclk2_q <= pclk2_s;
            if (cc1_load) begin
                cc1_q <= cc_primary_request;
            end
            if (cc2_load) begin
                cc2_q <= cc_secondary_request;
            end
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = dat_r_q;
    assign trigger_active = trig_lvl_q;
    assign trigger_pulse = trig_pulse_q;
    assign encoder_active = enc_lvl_q;
    assign encoder_pulse = enc_pulse_q;
    assign frame_end_irq = irq_q;
    assign camera_control_output_primary = cc1_q;
    assign camera_control_output_secondary = cc2_q;
endmodule

// ===== pkg/trig_enc_pkg.sv
// constants, types and register layout of the trigger and encoder select block
// Summary of operation
// - trigger source 0 diff, 1 ttl, 2 opto
// - source 3 uses frame valid, own polarity
// - trigger polarity 0 rising, 1 falling
// - soft trigger ORed, never inverted
// - encoder source 0 diff, 1 ttl, 2 opto
// - encoder polarity 0 rising, 1 falling
// - soft encoder ORed, never inverted
// - read live diff, ttl, opto trigger levels
// - read live diff, ttl, opto encoder levels
// - delay trigger by eight times N lines
// - frame end irq mask enables interrupt
// - frame end flag set at window end
// - start-stop mode: set flag on trigger release
// - host write 1 sets flag, 0 clears
// - flag writes need command code 6
// - interrupt only when flag and mask set
// - read live frame valid level
// - sync select 0 none, 1 primary pixel clock
// - select 2 secondary, 3 own camera clock
// - trigger enable gates hardware trigger
// - encoder enable gates hardware encoder
package trig_enc_pkg;
    localparam logic [7:0] TEC_OFFSET = 8'h00;
    localparam logic [7:0] ACQ_OFFSET = 8'h04;
    localparam logic [7:0] CFG_OFFSET = 8'h08;
    localparam logic [31:0] TEC_RESET = 32'h0000_0000;
    localparam logic [31:0] TEC_RW_MASK = 32'hF8FF_C0FF;
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam int TRIG_SEL_LSB = 0;
    localparam int TRIG_POL_BIT = 2;
    localparam int SOFT_TRIG_BIT = 3;
    localparam int ENC_SEL_LSB = 4;
    localparam int ENC_POL_BIT = 6;
    localparam int SOFT_ENC_BIT = 7;
    localparam int TRIG_LEVEL_LSB = 8;
    localparam int ENC_LEVEL_LSB = 11;
    localparam int DELAY_LSB = 14;
    localparam int DELAY_W = 10;
    localparam int FV_LEVEL_BIT = 26;
    localparam int CAMERA_CONTROL_SYNC_SELECT_LSB = 27;
    localparam int TRIG_EN_BIT = 30;
    localparam int ENC_EN_BIT = 31;
    localparam int IRQ_MASK_BIT = 24;
    localparam int EOF_FLAG_BIT = 25;
    localparam int CMD_LSB = 0;
    localparam int FV_POL_BIT = 4;
    localparam int START_STOP_BIT = 5;
    localparam logic [3:0] CMD_FLAG_WRITE = 4'h6;
    localparam int LINE_STEP_SHIFT = 3;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {SRC_DIFF, SRC_TTL, SRC_OPTO, SRC_CAMERA} src_sel_t;
    typedef enum logic [2:0] {CC_UNSYNC, CC_PRIMARY, CC_SECONDARY, CC_OWN} camera_control_sync_select_t;

    typedef struct packed {
        logic opto;
        logic ttl;
        logic diff;
    } io_pins_t;
endpackage

// ===== sim/ext_source.sv
// model of the camera pixel clocks and line timing beside the block
`timescale 1ns/1ps
module ext_source (
    input wire logic mclk,
    input wire logic [1:0] pclk_run,
    input wire logic line_run,
    output logic primary_pixel_clock,
    output logic secondary_pixel_clock,
    output logic line_pulse
);
    logic [3:0] cnt_q = 4'h0;
    always @(posedge mclk) begin
        cnt_q <= cnt_q + 4'h1;
    end
    // pixel clocks stand low while stopped, so no edge slips through
    assign primary_pixel_clock = pclk_run[0] & cnt_q[1];
    assign secondary_pixel_clock = pclk_run[1] & cnt_q[2];
    assign line_pulse = line_run & (cnt_q[1:0] == 2'h3);
endmodule

// ===== sim/trigger_encoder_select_assertions.sv
// bus and trigger path checks on the trigger encoder select ports
`timescale 1ns/1ps
module trigger_encoder_select_assertions (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    input wire trig_enc_pkg::io_pins_t trigger_pins,
    input wire trig_enc_pkg::io_pins_t encoder_pins,
    input wire logic frame_valid,
    input wire logic trigger_active,
    input wire logic trigger_pulse,
    input wire logic encoder_active,
    input wire logic encoder_pulse,
    input wire logic frame_end_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic rd_q;
    logic wr_q;
    logic [7:0] adr_q;
    logic [3:0] sel_q;
    logic [31:0] dat_q;
    // remember the request being answered
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= wb_cyc && wb_stb && !wb_ack && !wb_we;
            wr_q <= wb_cyc && wb_stb && !wb_ack && wb_we;
        end
    end
    always_ff @(posedge mclk) begin
        adr_q <= wb_adr;
        sel_q <= wb_sel;
        dat_q <= wb_dat_w;
    end
    ack_once_a: assert property (wb_ack |=> !wb_ack) else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack) else $error("request not answered");
    unmapped_zero_a: assert property (wb_ack && rd_q && adr_q > 8'h08 |-> wb_dat_r == 32'h0)
        else $error("unmapped read not zero");
    irq_gate_a: assert property (wb_ack && rd_q && adr_q == trig_enc_pkg::ACQ_OFFSET |->
        frame_end_irq == (wb_dat_r[24] && wb_dat_r[25])) else $error("irq not flag and mask");
    trig_level_a: assert property (wb_ack && rd_q && adr_q == 8'h00 && $past(trigger_pins, 4) == trigger_pins
        && $stable(trigger_pins) |-> wb_dat_r[10:8] == trigger_pins) else $error("trigger level readback");
    enc_level_a: assert property (wb_ack && rd_q && adr_q == 8'h00 && $past(encoder_pins, 4) == encoder_pins
        && $stable(encoder_pins) |-> wb_dat_r[13:11] == encoder_pins) else $error("encoder level readback");
    fv_level_a: assert property (wb_ack && rd_q && adr_q == 8'h00 && $past(frame_valid, 4) == frame_valid
        && $stable(frame_valid) |-> wb_dat_r[26] == frame_valid) else $error("frame valid readback");
    soft_trig_a: assert property (wb_ack && wr_q && adr_q == 8'h00 && sel_q[0] && dat_q[3]
        |=> trigger_active) else $error("soft trigger not active");
    soft_enc_a: assert property (wb_ack && wr_q && adr_q == 8'h00 && sel_q[0] && dat_q[7]
        |=> encoder_active) else $error("soft encoder not active");
    enc_edge_a: assert property (encoder_pulse |-> encoder_active && !$past(encoder_active))
        else $error("encoder pulse off edge");
    trig_single_a: assert property (trigger_pulse |=> !trigger_pulse) else $error("trigger pulse too long");
endmodule

// ===== sim/trigger_encoder_select_test.sv
// self-checking bench for the trigger encoder select block
`timescale 1ns/1ps
module trigger_encoder_select_test;
    localparam logic [7:0] TEC = trig_enc_pkg::TEC_OFFSET;
    localparam logic [7:0] ACQ = trig_enc_pkg::ACQ_OFFSET;
    localparam logic [7:0] CFG = trig_enc_pkg::CFG_OFFSET;
    logic mclk, reset, wb_cyc, wb_stb, wb_we, wb_ack, frame_valid, vertical_active_window, line_run;
    logic primary_pixel_clock, secondary_pixel_clock, line_pulse, frame_end_irq;
    logic trigger_active, trigger_pulse, encoder_active, encoder_pulse, act_d;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel, cc_primary_request, cc_secondary_request, op, os, ep, es;
    logic [3:0] camera_control_output_primary, camera_control_output_secondary;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [2:0] p;
    logic [1:0] pclk_run;
    trig_enc_pkg::io_pins_t trigger_pins, encoder_pins;
    int n_errors, n_checks, t_pulses, e_pulses, lines, got_lines, i;

    trigger_encoder_select dut (.mclk, .reset, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
        .wb_dat_r, .wb_ack, .trigger_pins, .encoder_pins, .frame_valid, .primary_pixel_clock,
        .secondary_pixel_clock, .line_pulse, .vertical_active_window, .cc_primary_request,
        .cc_secondary_request, .trigger_active, .trigger_pulse, .encoder_active, .encoder_pulse,
        .frame_end_irq, .camera_control_output_primary, .camera_control_output_secondary);
    ext_source src (.mclk, .pclk_run, .line_run, .primary_pixel_clock, .secondary_pixel_clock, .line_pulse);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // counts pulses and the lines seen from trigger rise to delayed pulse
    always @(posedge mclk) begin
        if (trigger_active === 1'b1 && act_d !== 1'b1) lines = 0;
        if (trigger_pulse === 1'b1) got_lines = lines;
        if (line_pulse === 1'b1) lines++;
        if (trigger_pulse === 1'b1) t_pulses++;
        if (encoder_pulse === 1'b1) e_pulses++;
        act_d = trigger_active;
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel,
        output logic [31:0] q);
        int k;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= d;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        if (wb_ack !== 1'b1) begin
            n_errors++;
            finish_test();
        end
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] q;
        bus(1'b1, adr, d, sel, q);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, adr, 32'h0, 4'hF, q);
        check(q, exp);
    endtask

    task automatic cfg_check(input logic [31:0] ctrl, input logic et, input logic ee);
        wr(TEC, ctrl, 4'hF);
        repeat (4) @(posedge mclk);
        check({30'h0, trigger_active, encoder_active}, {30'h0, et, ee});
    endtask

    initial begin
        reset = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = '0;
        {trigger_pins, encoder_pins, frame_valid, vertical_active_window, line_run, pclk_run} = '0;
        cc_primary_request = 4'h5;
        cc_secondary_request = 4'hA;
        {n_errors, n_checks, t_pulses, e_pulses, lines} = '0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(TEC, 32'h0);
        rd(ACQ, 32'h0);
        rd(CFG, 32'h0);
        rd(8'h0C, 32'h0);
        // soft trigger kept clear: an event here would arm the longest delay for the rest of the run
        wr(TEC, 32'hFFFF_FFF7, 4'hF);
        rd(TEC, trig_enc_pkg::TEC_RW_MASK & 32'hFFFF_FFF7);
        wr(TEC, 32'h0, 4'h1);
        rd(TEC, 32'hF8FF_C000);
        wr(TEC, 32'h0, 4'hF);
        trigger_pins <= 3'b101;
        encoder_pins <= 3'b011;
        frame_valid <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(TEC, 32'h0400_1D00);
        for (int s = 0; s < 3; s++) begin
            p = 3'b001 << s;
            for (int k = 0; k < 2; k++) begin
                trigger_pins <= (k == 1) ? ~p : p;
                encoder_pins <= (k == 1) ? ~p : p;
                cfg_check(32'hC000_0000 | 32'(s) | (32'(s) << 4), k == 0, k == 0);
                cfg_check(32'hC000_0044 | 32'(s) | (32'(s) << 4), k == 1, k == 1);
                cfg_check(32'(s) | (32'(s) << 4), 1'b0, 1'b0);
            end
        end
        trigger_pins <= 3'b000;
        encoder_pins <= 3'b111;
        cfg_check(32'hC000_0037, 1'b1, 1'b0);
        wr(CFG, 32'h10, 4'h1);
        cfg_check(32'hC000_0037, 1'b0, 1'b0);
        // disable first so the polarity change makes no trigger edge before the pulse count
        wr(TEC, 32'h0, 4'hF);
        wr(CFG, 32'h0, 4'h1);
        frame_valid <= 1'b0;
        encoder_pins <= 3'b000;
        t_pulses = 0;
        e_pulses = 0;
        cfg_check(32'h0000_00CC, 1'b1, 1'b1);
        check(32'(t_pulses), 32'h1);
        check(32'(e_pulses), 32'h1);
        wr(TEC, 32'h0, 4'hF);
        line_run <= 1'b1;
        wr(TEC, 32'h0000_4000, 4'hF);
        got_lines = -1;
        wr(TEC, 32'h0000_4008, 4'hF);
        for (i = 0; i < 200 && got_lines < 0; i++) @(posedge mclk);
        check(32'(got_lines), 32'h8);
        wr(TEC, 32'h0, 4'hF);
        line_run <= 1'b0;
        wr(ACQ, 32'h0100_0000, 4'h8);
        vertical_active_window <= 1'b1;
        repeat (3) @(posedge mclk);
        vertical_active_window <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(ACQ, 32'h0300_0000);
        check(32'(frame_end_irq), 32'h1);
        wr(ACQ, 32'h0100_0000, 4'h8);
        rd(ACQ, 32'h0300_0000);
        wr(CFG, 32'h6, 4'h1);
        wr(ACQ, 32'h0100_0000, 4'h8);
        rd(ACQ, 32'h0100_0000);
        wr(ACQ, 32'h0300_0000, 4'h8);
        rd(ACQ, 32'h0300_0000);
        wr(ACQ, 32'h0200_0000, 4'h8);
        rd(ACQ, 32'h0200_0000);
        check(32'(frame_end_irq), 32'h0);
        wr(ACQ, 32'h0, 4'h8);
        wr(CFG, 32'h26, 4'h1);
        wr(TEC, 32'h8, 4'hF);
        rd(ACQ, 32'h0);
        wr(TEC, 32'h0, 4'hF);
        repeat (3) @(posedge mclk);
        rd(ACQ, 32'h0200_0000);
        check(32'({camera_control_output_primary, camera_control_output_secondary}), 32'h5A);
        op = 4'h5;
        os = 4'hA;
        for (int c = 1; c < 4; c++) begin
            wr(TEC, 32'(c) << 27, 4'hF);
            pclk_run <= 2'b00;
            repeat (8) @(posedge mclk);
            cc_primary_request <= 4'(c);
            cc_secondary_request <= 4'(c + 8);
            repeat (10) @(posedge mclk);
            check(32'({camera_control_output_primary, camera_control_output_secondary}), 32'({op, os}));
            pclk_run <= 2'b01;
            repeat (12) @(posedge mclk);
            ep = (c != 2) ? 4'(c) : op;
            es = (c == 1) ? 4'(c + 8) : os;
            check(32'({camera_control_output_primary, camera_control_output_secondary}), 32'({ep, es}));
            pclk_run <= 2'b11;
            repeat (20) @(posedge mclk);
            op = 4'(c);
            os = 4'(c + 8);
            check(32'({camera_control_output_primary, camera_control_output_secondary}), 32'({op, os}));
        end
        finish_test();
    end
endmodule

bind trigger_encoder_select trigger_encoder_select_assertions chk (.mclk, .reset, .wb_cyc, .wb_stb, .wb_we,
    .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .trigger_pins, .encoder_pins, .frame_valid,
    .trigger_active, .trigger_pulse, .encoder_active, .encoder_pulse, .frame_end_irq);
